// >>> dv/cpu_model.sv
// Byte-wide CPU bus master driving the timer register port
`timescale 1ns/1ns
module cpu_model (
    // Clock
    input  wire logic       clock,
    // Register port
    output logic [3:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_write,
    output logic            reg_read,
    input  wire logic [7:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    // Released data shows the inverse, so stale bytes never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // High byte then low byte on consecutive cycles
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_addr  <= a + 4'h1;
        reg_wdata <= v[15:8];
        reg_write <= 1'b1;
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v[7:0];
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~v[7:0];
        #1;
    endtask
    // Data is taken once the update after the read edge has landed
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Low byte first so the holding register captures the matching high byte
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 4'h1, v[15:8]);
    endtask
endmodule

// >>> dv/tb.sv
// Self-checking testbench for the 16-bit timer core
`timescale 1ns/1ns
`define chk(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic       clock = 1'b0;
    logic       rst_n;
    logic       overflow_ack;
    logic       compare_ack;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic       overflow_irq;
    logic       compare_irq;
    logic       at_bottom;
    logic       at_max;
    logic       at_top;
    logic [7:0] b;
    logic [15:0] w;
    int         n_errors = 0;
    int         checks_done = 0;
    always #2 clock = ~clock;
    timer16_core i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .overflow_irq(overflow_irq),
        .compare_irq(compare_irq), .overflow_ack(overflow_ack), .compare_ack(compare_ack),
        .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
    cpu_model i_cpu (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata));
    task automatic final_report();
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Run the counter with a control byte for n cycles, then stop it
    task automatic run(input logic [7:0] cb, input int n);
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, cb);
        repeat (n) @(posedge clock);
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
    endtask
    // Count from start at full rate until the chosen irq rises, bounded
    task automatic hit(input bit ovf, input logic [15:0] start);
        int i;
        i = 0;
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, start);
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, 8'h01);
        while ((ovf ? overflow_irq : compare_irq) !== 1'b1 && i < 60) begin
            @(posedge clock);
            i++;
        end
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
        `chk(ovf ? overflow_irq : compare_irq, 1'b1)
    endtask
    // One-cycle interrupt-executed pulse
    task automatic ack(input bit ovf);
        @(posedge clock);
        if (ovf) overflow_ack <= 1'b1;
        else compare_ack <= 1'b1;
        @(posedge clock);
        overflow_ack <= 1'b0;
        compare_ack  <= 1'b0;
        #1;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        overflow_ack = 1'b0;
        compare_ack = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            i_cpu.rd(4'(a), b);
            `chk(b, 8'h00)
        end
        `chk(at_bottom, 1'b1)
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_A, 8'hFF);
        i_cpu.rd(timer16_pkg::ADDR_CONTROL_A, b);
        `chk(b, 8'h03)
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, 8'hF8);
        i_cpu.rd(timer16_pkg::ADDR_CONTROL_B, b);
        `chk(b, 8'h18)
        i_cpu.wr(timer16_pkg::ADDR_CONTROL_B, 8'h00);
        // Shared holding register across counter and compare
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, 16'h1234);
        i_cpu.wr16(timer16_pkg::ADDR_COMPARE_LO, 16'hABCD);
        i_cpu.rd(timer16_pkg::ADDR_COUNT_LO, b);
        `chk(b, 8'h34)
        i_cpu.rd16(timer16_pkg::ADDR_COMPARE_LO, w);
        `chk(w, 16'hABCD)
        i_cpu.rd(timer16_pkg::ADDR_COUNT_HI, b);
        `chk(b, 8'h12)
        i_cpu.wr(timer16_pkg::ADDR_COMPARE_HI, 8'h56);
        i_cpu.wr(timer16_pkg::ADDR_COUNT_LO, 8'h78);
        repeat (20) @(posedge clock);
        i_cpu.rd16(timer16_pkg::ADDR_COUNT_LO, w);
        `chk(w, 16'h5678)
        // Power-off holds the counter even with a clock selected
        i_cpu.wr(timer16_pkg::ADDR_POWER, 8'h08);
        i_cpu.rd(timer16_pkg::ADDR_POWER, b);
        `chk(b, 8'h08)
        run(8'h01, 20);
        i_cpu.rd16(timer16_pkg::ADDR_COUNT_LO, w);
        `chk(w, 16'h5678)
        i_cpu.wr(timer16_pkg::ADDR_POWER, 8'h00);
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, 16'hFFFF);
        `chk(at_max, 1'b1)
        `chk(at_top, 1'b1)
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, 16'h0000);
        `chk(at_bottom, 1'b1)
        // Counter written equal to compare: first match is blocked
        i_cpu.wr16(timer16_pkg::ADDR_COMPARE_LO, 16'h0020);
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, 16'h0020);
        i_cpu.wr(timer16_pkg::ADDR_IRQ_MASK, 8'h03);
        run(8'h01, 10);
        `chk(compare_irq, 1'b0)
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h00)
        hit(1'b0, 16'h0010);
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h02)
        i_cpu.wr(timer16_pkg::ADDR_IRQ_FLAG, 8'h02);
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h00)
        hit(1'b0, 16'h0018);
        i_cpu.wr(timer16_pkg::ADDR_IRQ_MASK, 8'h01);
        `chk(compare_irq, 1'b0)
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h02)
        ack(1'b0);
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h00)
        hit(1'b1, 16'hFFFC);
        i_cpu.rd(timer16_pkg::ADDR_IRQ_FLAG, b);
        `chk(b, 8'h01)
        ack(1'b1);
        `chk(overflow_irq, 1'b0)
        // Compare-as-top mode wraps at the compare value
        i_cpu.wr16(timer16_pkg::ADDR_COMPARE_LO, 16'h0005);
        i_cpu.wr16(timer16_pkg::ADDR_COUNT_LO, 16'h0000);
        run(8'h09, 50);
        i_cpu.rd16(timer16_pkg::ADDR_COUNT_LO, w);
        `chk(w, 16'h0004)
        final_report();
    end
endmodule

// >>> dv/timer16_sva.sv
// Port-level assertions for the 16-bit timer core
`timescale 1ns/1ns
module timer16_sva (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Interrupts and status
    input wire logic       overflow_irq,
    input wire logic       compare_irq,
    input wire logic       overflow_ack,
    input wire logic       compare_ack,
    input wire logic       at_bottom,
    input wire logic       at_max,
    input wire logic       at_top
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Two strobes of a 16-bit counter write, high byte first
    sequence cnt_hi(v);
        reg_write && reg_addr == timer16_pkg::ADDR_COUNT_HI && reg_wdata == v;
    endsequence
    sequence cnt_lo(v);
        reg_write && reg_addr == timer16_pkg::ADDR_COUNT_LO && reg_wdata == v;
    endsequence
    // Read data stands only in the cycle after a read
    a_idle_rdata: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property ($past(reg_read) && $past(reg_addr) > timer16_pkg::ADDR_POWER
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_ctrl_reserved: assert property ($past(reg_read) && $past(reg_addr) == timer16_pkg::ADDR_CONTROL_A
        |-> reg_rdata[7:2] == 6'h00) else $error("control reserved bits set");
    a_flag_reserved: assert property ($past(reg_read) && $past(reg_addr) == timer16_pkg::ADDR_IRQ_FLAG
        |-> reg_rdata[7:2] == 6'h00) else $error("flag reserved bits set");
    a_mask_gates_irq: assert property (reg_write && reg_addr == timer16_pkg::ADDR_IRQ_MASK
        |=> (!overflow_irq || $past(reg_wdata[0])) && (!compare_irq || $past(reg_wdata[1])))
        else $error("irq despite mask");
    a_bottom_not_max: assert property (at_bottom |-> !at_max)
        else $error("bottom and max together");
    a_reset_quiet: assert property ($rose(rst_n) |-> at_bottom && !overflow_irq && !compare_irq)
        else $error("state not cleared by reset");
    // Ack outside a max cycle cannot race a new overflow
    a_ovf_ack_clear: assert property (overflow_ack && !at_max |=> !overflow_irq)
        else $error("overflow ack ignored");
    a_write_bottom: assert property (cnt_hi(8'h00) ##1 cnt_lo(8'h00) |=> at_bottom)
        else $error("counter write of zero lost");
    a_write_max: assert property (cnt_hi(8'hFF) ##1 cnt_lo(8'hFF) |=> at_max && !at_bottom)
        else $error("counter write of max lost");
endmodule
bind timer16_core timer16_sva i_sva (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .overflow_irq(overflow_irq), .compare_irq(compare_irq), .overflow_ack(overflow_ack),
    .compare_ack(compare_ack), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

// >>> hw/timer16_core.sv
// 16-bit timer/counter with shared high-byte holding register and one compare channel
//
// What this block does
// - Counter and compare A are 16-bit registers reached over an 8-bit bus.
// - One 8-bit high-byte holding register is shared by all 16-bit registers.
// - Low-byte write loads low byte and held high byte together.
// - Counter low-byte read copies the counter high byte into the holding register.
// - Compare A reads return both bytes directly, holding register untouched.
// - Both control registers are read/write, unused bits masked to zero (A keeps 2 bits, B keeps 5).
// - Each interrupt request shows in the flag register and has a mask bit.
// - Counter advances only on prescaled ticks; stopped with no clock source.
// - Compare A is matched against the counter continuously; a match on a timer tick sets flag.
// - Top value depends on mode: compare A or fixed maximum.
// - Bottom signalled at 0x0000, maximum at 0xFFFF.
// - Overflow and compare match are separate, separately masked sources.
// - Compare flag clears on interrupt acknowledge or writing one to it.
// - CPU counter write beats any clear or count in the same cycle.
// - Counter write blocks compare matches on the next timer tick.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module timer16_core (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // Interrupt requests and acknowledges
    output logic            overflow_irq,
    output logic            compare_irq,
    input  wire logic       overflow_ack,
    input  wire logic       compare_ack,
    // Counter status
    output logic            at_bottom,
    output logic            at_max,
    output logic            at_top
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] count_value;
    logic [15:0] compare_value_a;
    logic [7:0]  high_byte_hold;
    logic [7:0]  timer_control_a;
    logic [7:0]  timer_control_b;
    logic        overflow_flag;
    logic        compare_match_flag;
    logic        overflow_irq_enable;
    logic        compare_irq_enable;
    logic        timer_power_off;

    logic        timer_tick;
    logic        compare_hit;
    logic        count_write;
    logic [15:0] top_value;
    logic [15:0] next_count;
    logic        overflow_event;
    logic [1:0]  mode;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_write(input logic [3:0] addr, input logic [3:0] target,
                                      input logic strobe);
        is_write = strobe && (addr == target);
    endfunction

    assign count_write = is_write(reg_addr, timer16_pkg::ADDR_COUNT_LO, reg_write);
    assign mode        = {timer_control_b[timer16_pkg::WGM_HI_POS + 1],
                          timer_control_b[timer16_pkg::WGM_HI_POS]};

    // ------------------------------------------------------------
    // Clock select and comparator
    // ------------------------------------------------------------
    // Powered-off module gets no ticks at all
    timer_prescaler u_prescaler (
        .clock        (clock),
        .rst_n        (rst_n),
        .enable       (!timer_power_off),
        .clock_select (timer_control_b[timer16_pkg::CS_POS +: 3]),
        .timer_tick   (timer_tick)
    );

    timer_compare_unit u_compare (
        .clock           (clock),
        .rst_n           (rst_n),
        .count_value     (count_value),
        .compare_value_a (compare_value_a),
        .timer_tick      (timer_tick),
        .count_write     (count_write),
        .compare_hit     (compare_hit),
        .match_now       ()
    );

    // ------------------------------------------------------------
    // Counter sequence
    // ------------------------------------------------------------
    // CTC mode tops out at compare A, all others run to the fixed maximum
    always_comb begin
        if (timer16_pkg::count_mode_t'(mode) == timer16_pkg::MODE_CTC) begin
            top_value = compare_value_a;
        end else begin
            top_value = timer16_pkg::MAX_VALUE;
        end
    end

    assign at_bottom = (count_value == timer16_pkg::BOTTOM_VALUE);
    assign at_max    = (count_value == timer16_pkg::MAX_VALUE);
    assign at_top    = (count_value == top_value);

    // Wrap at top; overflow is raised when the count passes MAX to zero
    always_comb begin
        if (count_value == top_value) begin
            next_count = timer16_pkg::BOTTOM_VALUE;
        end else begin
            next_count = count_value + 16'h0001;
        end
    end

    assign overflow_event = timer_tick && !count_write && at_max;

    // CPU write wins over counting; high byte always comes from the hold register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= timer16_pkg::RESET_WORD;
        end else if (count_write) begin
            count_value <= {high_byte_hold, reg_wdata};
        end else if (timer_tick) begin
            count_value <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Compare register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_value_a <= timer16_pkg::RESET_WORD;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_COMPARE_LO, reg_write)) begin
            compare_value_a <= {high_byte_hold, reg_wdata};
        end
    end

    // ------------------------------------------------------------
    // Shared high-byte holding register
    // ------------------------------------------------------------
    // Written by any high-byte write; loaded only by a counter low read,
    // since compare reads go direct and must not disturb it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            high_byte_hold <= timer16_pkg::RESET_BYTE;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_COUNT_HI, reg_write) ||
                     is_write(reg_addr, timer16_pkg::ADDR_COMPARE_HI, reg_write)) begin
            high_byte_hold <= reg_wdata;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_COUNT_LO, reg_read)) begin
            high_byte_hold <= count_value[15:8];
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_a <= timer16_pkg::RESET_BYTE;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_CONTROL_A, reg_write)) begin
            timer_control_a <= reg_wdata & timer16_pkg::CTRL_A_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_b <= timer16_pkg::RESET_BYTE;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_CONTROL_B, reg_write)) begin
            timer_control_b <= reg_wdata & timer16_pkg::CTRL_B_MASK;
        end
    end

    // Power bit resets to zero so the timer is usable out of reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_power_off <= 1'b0;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_POWER, reg_write)) begin
            timer_power_off <= reg_wdata[timer16_pkg::POWER_BIT];
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags and masks
    // ------------------------------------------------------------
    // Set beats clear so an event in the clearing cycle is not lost
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
        end else if (overflow_event) begin
            overflow_flag <= 1'b1;
        end else if (overflow_ack ||
                     (is_write(reg_addr, timer16_pkg::ADDR_IRQ_FLAG, reg_write) &&
                      reg_wdata[timer16_pkg::OVF_BIT])) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compare_match_flag <= 1'b0;
        end else if (compare_hit) begin
            compare_match_flag <= 1'b1;
        end else if (compare_ack ||
                     (is_write(reg_addr, timer16_pkg::ADDR_IRQ_FLAG, reg_write) &&
                      reg_wdata[timer16_pkg::CMP_BIT])) begin
            compare_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overflow_irq_enable <= 1'b0;
            compare_irq_enable  <= 1'b0;
        end else if (is_write(reg_addr, timer16_pkg::ADDR_IRQ_MASK, reg_write)) begin
            overflow_irq_enable <= reg_wdata[timer16_pkg::OVF_BIT];
            compare_irq_enable  <= reg_wdata[timer16_pkg::CMP_BIT];
        end
    end

    assign overflow_irq = overflow_flag && overflow_irq_enable;
    assign compare_irq  = compare_match_flag && compare_irq_enable;

    // ------------------------------------------------------------
    // Read data, registered one cycle after the read strobe
    // ------------------------------------------------------------
    // Count high reads the hold register, so a wide read must start low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= timer16_pkg::RESET_BYTE;
        end else if (!reg_read) begin
            reg_rdata <= timer16_pkg::RESET_BYTE;
        end else if (reg_addr == timer16_pkg::ADDR_CONTROL_A) begin
            reg_rdata <= timer_control_a;
        end else if (reg_addr == timer16_pkg::ADDR_CONTROL_B) begin
            reg_rdata <= timer_control_b;
        end else if (reg_addr == timer16_pkg::ADDR_COUNT_LO) begin
            reg_rdata <= count_value[7:0];
        end else if (reg_addr == timer16_pkg::ADDR_COUNT_HI) begin
            reg_rdata <= high_byte_hold;
        end else if (reg_addr == timer16_pkg::ADDR_COMPARE_LO) begin
            reg_rdata <= compare_value_a[7:0];
        end else if (reg_addr == timer16_pkg::ADDR_COMPARE_HI) begin
            reg_rdata <= compare_value_a[15:8];
        end else if (reg_addr == timer16_pkg::ADDR_IRQ_FLAG) begin
            reg_rdata <= {6'h00, compare_match_flag, overflow_flag};
        end else if (reg_addr == timer16_pkg::ADDR_IRQ_MASK) begin
            reg_rdata <= {6'h00, compare_irq_enable, overflow_irq_enable};
        end else if (reg_addr == timer16_pkg::ADDR_POWER) begin
            reg_rdata <= {4'h0, timer_power_off, 3'h0};
        end else begin
            reg_rdata <= timer16_pkg::RESET_BYTE;                            // Unmapped reads zero
        end
    end

endmodule

// >>> hw/timer16_pkg.sv
// Constants for the 16-bit timer access core: register map, field positions, reset values
package timer16_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the 8-bit port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL_A   = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_B   = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LO    = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HI    = 4'h3;
    localparam logic [3:0] ADDR_COMPARE_LO  = 4'h4;
    localparam logic [3:0] ADDR_COMPARE_HI  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_FLAG    = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h7;
    localparam logic [3:0] ADDR_POWER       = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OVF_BIT      = 0;
    localparam int CMP_BIT      = 1;
    localparam int POWER_BIT    = 3;
    localparam int WGM_LO_POS   = 0;  // control_a[1:0]
    localparam int WGM_HI_POS   = 3;  // control_b[4:3]
    localparam int CS_POS       = 0;  // control_b[2:0]

    // ------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [15:0] BOTTOM_VALUE = 16'h0000;
    localparam logic [15:0] MAX_VALUE    = 16'hFFFF;
    localparam logic [7:0]  CTRL_A_MASK  = 8'h03;
    localparam logic [7:0]  CTRL_B_MASK  = 8'h1F;
    localparam logic [7:0]  FLAG_MASK    = 8'h03;
    localparam logic [7:0]  POWER_MASK   = 8'h08;

    // ------------------------------------------------------------
    // Prescaler divide ratios
    // ------------------------------------------------------------
    localparam int PRESCALE_WIDTH = 10;
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV64_MASK   = 10'h03F;
    localparam logic [9:0] DIV256_MASK  = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;

    // ------------------------------------------------------------
    // Clock select and counting modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_STOP    = 3'b000,
        CS_DIV1    = 3'b001,
        CS_DIV8    = 3'b010,
        CS_DIV64   = 3'b011,
        CS_DIV256  = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_RSVD6   = 3'b110,
        CS_RSVD7   = 3'b111
    } clock_sel_t;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_CTC    = 2'b01,
        MODE_RSVD2  = 2'b10,
        MODE_RSVD3  = 2'b11
    } count_mode_t;

endpackage

// >>> hw/timer_compare_unit.sv
// Continuous 16-bit comparator with match blocking after a counter write
`timescale 1ns/1ns
module timer_compare_unit (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Operands
    input  wire logic [15:0] count_value,
    input  wire logic [15:0] compare_value_a,
    // Timing
    input  wire logic        timer_tick,
    input  wire logic        count_write,
    // Result
    output logic             compare_hit,
    output logic             match_now
);

    logic block_pending;

    assign match_now = (count_value == compare_value_a);

    // ------------------------------------------------------------
    // A counter write arms a block that lasts until the next timer tick
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            block_pending <= 1'b0;
        end else if (count_write) begin
            block_pending <= 1'b1;
        end else if (timer_tick) begin
            block_pending <= 1'b0;
        end
    end

    // Match is counted on a tick unless blocked; writes in this cycle block too
    assign compare_hit = timer_tick && match_now && !block_pending && !count_write;

endmodule

// >>> hw/timer_prescaler.sv
// Prescaler and clock-select logic producing the one-cycle timer tick
`timescale 1ns/1ns
module timer_prescaler (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Control
    input  wire logic       enable,
    input  wire logic [2:0] clock_select,
    // Tick out
    output logic            timer_tick
);

    logic [9:0] prescale_count;

    // ------------------------------------------------------------
    // Free-running divider, held at zero while the module is off
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count <= 10'h000;
        end else if (!enable) begin
            prescale_count <= 10'h000;
        end else begin
            prescale_count <= prescale_count + 10'h001;
        end
    end

    // Tick when the low bits of the divider are all ones; reserved codes stop
    always_comb begin
        case (timer16_pkg::clock_sel_t'(clock_select))
            timer16_pkg::CS_DIV1:    timer_tick = enable;
            timer16_pkg::CS_DIV8:    timer_tick = enable && ((prescale_count & timer16_pkg::DIV8_MASK)
                                                             == timer16_pkg::DIV8_MASK);
            timer16_pkg::CS_DIV64:   timer_tick = enable && ((prescale_count & timer16_pkg::DIV64_MASK)
                                                             == timer16_pkg::DIV64_MASK);
            timer16_pkg::CS_DIV256:  timer_tick = enable && ((prescale_count & timer16_pkg::DIV256_MASK)
                                                             == timer16_pkg::DIV256_MASK);
            timer16_pkg::CS_DIV1024: timer_tick = enable && (prescale_count == timer16_pkg::DIV1024_MASK);
            default:                 timer_tick = 1'b0;
        endcase
    end

endmodule
